// ---- include/asrc_pkg.sv ----
// asrc_pkg: constants and carrier types for the async sram host controller
// assumes a 20 MHz system clock; sram timings other than OUTPUT_ACCESS_NS are rounded to whole cycles
package asrc_pkg;

  localparam int unsigned CLOCK_MHZ     = 20;
  localparam int unsigned CLOCK_NS      = 1000 / CLOCK_MHZ;

  localparam int unsigned ADDR_WIDTH    = 18;
  localparam int unsigned DATA_WIDTH    = 16;
  localparam int unsigned LANE_COUNT    = 2;

  // least times round up
  localparam int unsigned READ_ACCESS_NS     = 70;
  localparam int unsigned OUTPUT_ACCESS_NS   = 35;
  localparam int unsigned RELEASE_NS         = 25;
  localparam int unsigned SELECT_TO_END_NS   = 30;
  localparam int unsigned ADDR_TO_END_NS     = 30;
  localparam int unsigned DATA_TO_END_NS     = 25;
  localparam int unsigned WRITE_RECOVERY_NS  = 0;

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLOCK_NS - 1) / CLOCK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int unsigned READ_CYCLES     = ns_to_cycles(READ_ACCESS_NS);
  localparam int unsigned RELEASE_CYCLES  = ns_to_cycles(RELEASE_NS);
  localparam int unsigned WRITE_CYCLES    = ns_to_cycles(SELECT_TO_END_NS > ADDR_TO_END_NS ?
                                                          SELECT_TO_END_NS : ADDR_TO_END_NS);
  localparam int unsigned DATA_CYCLES     = ns_to_cycles(DATA_TO_END_NS);
  localparam int unsigned RECOVERY_CYCLES = ns_to_cycles(WRITE_RECOVERY_NS);
  localparam int unsigned COUNT_WIDTH     = 4;

  // pins driven toward the sram
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] address;
    logic                  ram_select_active_low;
    logic                  ram_select_active_high;
    logic                  ram_write_strobe_n;
    logic                  ram_output_strobe_n;
    logic                  lower_byte_lane_n;
    logic                  upper_byte_lane_n;
  } asrc_pins_type;

  // user request
  typedef struct packed {
    logic                  write;
    logic [ADDR_WIDTH-1:0] address;
    logic [DATA_WIDTH-1:0] data;
    logic [LANE_COUNT-1:0] lanes;
  } asrc_request_type;

  localparam asrc_pins_type PINS_IDLE = '{
    address: '0, ram_select_active_low: 1'b1, ram_select_active_high: 1'b0,
    ram_write_strobe_n: 1'b1, ram_output_strobe_n: 1'b1,
    lower_byte_lane_n: 1'b1, upper_byte_lane_n: 1'b1};

endpackage : asrc_pkg

// ---- rtl/asrc_sync.sv ----
// asrc_sync: two-flop synchroniser for the sram data pins
// assumes the pins are asynchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module asrc_sync #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  // data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] first_q;
  logic [WIDTH-1:0] second_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_q  <= '0;
      second_q <= '0;
    end else begin
      first_q  <= i_async;
      second_q <= first_q;
    end
  end

  assign o_sync = second_q;
endmodule : asrc_sync
`default_nettype wire

// ---- rtl/asrc_host.sv ----
// asrc_host: host-side controller driving an asynchronous 256K x 16 sram
// assumes one 20 MHz clock; the sram has no clock, timing is met by counted cycles
`timescale 1ns/1ps
`default_nettype none
module asrc_host
  import asrc_pkg::*;
#(
  parameter int unsigned ADDR_BITS = asrc_pkg::ADDR_WIDTH,
  parameter int unsigned DATA_BITS = asrc_pkg::DATA_WIDTH
) (
  // clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_reset_n,
  // user request
  input  wire logic                        i_request_valid,
  output logic                             o_request_ready,
  input  wire asrc_pkg::asrc_request_type  i_request,
  // user answer
  output logic                             o_answer_valid,
  output logic [asrc_pkg::DATA_WIDTH-1:0]  o_answer_data,
  // sram pins
  output asrc_pkg::asrc_pins_type          o_pins,
  input  wire logic [asrc_pkg::DATA_WIDTH-1:0] i_ram_data,
  output logic [asrc_pkg::DATA_WIDTH-1:0]  o_ram_data,
  output logic [asrc_pkg::DATA_WIDTH-1:0]  o_ram_data_oe
);
  import asrc_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_READ    = 6'b000010,
    ST_WRITE   = 6'b000100,
    ST_RECOVER = 6'b001000,
    ST_RELEASE = 6'b010000,
    ST_DONE    = 6'b100000
  } asrc_state_type;

  asrc_state_type         state_q;
  logic [COUNT_WIDTH-1:0] count_q;
  asrc_pins_type          pins_q;
  logic [DATA_WIDTH-1:0]  wdata_q;
  logic [LANE_COUNT-1:0]  lanes_q;
  logic                   drive_q;
  logic                   answer_q;
  logic [DATA_WIDTH-1:0]  answer_data_q;
  logic [DATA_WIDTH-1:0]  ram_data_sync;

  function automatic logic [DATA_WIDTH-1:0] lane_mask(input logic [LANE_COUNT-1:0] lanes);
    return {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction : lane_mask

  asrc_sync #(.WIDTH(DATA_WIDTH)) u_sync (
    .i_clock  (i_clock),
    .i_reset_n(i_reset_n),
    .i_async  (i_ram_data),
    .o_sync   (ram_data_sync)
  );

  assign o_request_ready = (state_q == ST_IDLE);

  // sequencer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      count_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          count_q <= '0;
          if (i_request_valid && |i_request.lanes) begin
            state_q <= i_request.write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          // two extra cycles cover the data synchroniser
          count_q <= count_q + 1'b1;
          if (count_q == COUNT_WIDTH'(READ_CYCLES + 1)) begin
            state_q <= ST_RELEASE;
            count_q <= '0;
          end
        end
        ST_WRITE: begin
          count_q <= count_q + 1'b1;
          if (count_q == COUNT_WIDTH'(WRITE_CYCLES - 1)) begin
            state_q <= ST_RECOVER;
            count_q <= '0;
          end
        end
        ST_RECOVER: begin
          count_q <= count_q + 1'b1;
          if (count_q == COUNT_WIDTH'(RECOVERY_CYCLES - 1)) begin
            state_q <= ST_DONE;
            count_q <= '0;
          end
        end
        ST_RELEASE: begin
          count_q <= count_q + 1'b1;
          if (count_q == COUNT_WIDTH'(RELEASE_CYCLES - 1)) begin
            state_q <= ST_DONE;
            count_q <= '0;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          count_q <= '0;
        end
      endcase
    end
  end

  // pin drive
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_q <= PINS_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pins_q <= PINS_IDLE;
          if (i_request_valid && |i_request.lanes) begin
            // address and selects rise with the strobe in one edge
            pins_q.address                <= i_request.address;
            pins_q.ram_select_active_low  <= 1'b0;
            pins_q.ram_select_active_high <= 1'b1;
            pins_q.lower_byte_lane_n      <= ~i_request.lanes[0];
            pins_q.upper_byte_lane_n      <= ~i_request.lanes[1];
            pins_q.ram_write_strobe_n     <= ~i_request.write;
            pins_q.ram_output_strobe_n    <= i_request.write;
          end
        end
        ST_WRITE: begin
          if (count_q == COUNT_WIDTH'(WRITE_CYCLES - 1)) begin
            // strobe, selects and lanes end together; address stays
            pins_q.ram_write_strobe_n     <= 1'b1;
            pins_q.ram_select_active_low  <= 1'b1;
            pins_q.ram_select_active_high <= 1'b0;
            pins_q.lower_byte_lane_n      <= 1'b1;
            pins_q.upper_byte_lane_n      <= 1'b1;
          end
        end
        ST_READ: begin
          if (count_q == COUNT_WIDTH'(READ_CYCLES + 1)) begin
            pins_q                        <= PINS_IDLE;
            pins_q.address                <= pins_q.address;
          end
        end
        ST_RECOVER, ST_RELEASE, ST_DONE: begin
          pins_q.ram_output_strobe_n <= 1'b1;
        end
        default: begin
          pins_q <= PINS_IDLE;
        end
      endcase
    end
  end

  // write data bus
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdata_q <= '0;
      lanes_q <= '0;
      drive_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && i_request_valid && |i_request.lanes && i_request.write) begin
        // data valid from strobe fall, well over the 25 ns overlap
        wdata_q <= i_request.data;
        lanes_q <= i_request.lanes;
        drive_q <= 1'b1;
      end else if (state_q != ST_WRITE) begin
        drive_q <= 1'b0;
      end
    end
  end

  assign o_ram_data    = wdata_q;
  // output strobe is high whenever drive is on, so no contention
  assign o_ram_data_oe = drive_q ? lane_mask(lanes_q) : '0;
  assign o_pins        = pins_q;

  // read answer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      answer_q      <= 1'b0;
      answer_data_q <= '0;
    end else begin
      answer_q <= 1'b0;
      if (state_q == ST_READ && count_q == COUNT_WIDTH'(READ_CYCLES + 1)) begin
        // disabled lanes read as zero
        answer_data_q <= ram_data_sync & lane_mask(~{pins_q.upper_byte_lane_n,
                                                    pins_q.lower_byte_lane_n});
        answer_q      <= 1'b1;
      end
    end
  end

  assign o_answer_valid = answer_q;
  assign o_answer_data  = answer_data_q;
endmodule : asrc_host
`default_nettype wire

// ---- sim/asrc_host_monitor.sv ----
// asrc_host_monitor: pin shape and timing checks on asrc_host
// assumes a bind onto asrc_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module asrc_host_monitor
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic                       i_clock,
  input wire logic                       i_reset_n,
  // user side
  input wire logic                       i_request_valid,
  input wire logic                       o_request_ready,
  input wire asrc_pkg::asrc_request_type i_request,
  input wire logic                       o_answer_valid,
  // sram side
  input wire asrc_pkg::asrc_pins_type    o_pins,
  input wire logic [DATA_WIDTH-1:0]      o_ram_data,
  input wire logic [DATA_WIDTH-1:0]      o_ram_data_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire logic       take = i_request_valid && o_request_ready && (|i_request.lanes);
  wire logic       sel  = !o_pins.ram_select_active_low && o_pins.ram_select_active_high;
  wire logic [1:0] ln_n = {o_pins.upper_byte_lane_n, o_pins.lower_byte_lane_n};
  wire logic       we_n = o_pins.ram_write_strobe_n;
  wire logic       oe_n = o_pins.ram_output_strobe_n;
  property p_read_shape; !oe_n |-> sel && we_n && ln_n != 2'h3; endproperty
  a_read_shape: assert property (p_read_shape) else $error("read pins wrong");
  property p_write_shape; !we_n |-> sel && ln_n != 2'h3 && oe_n; endproperty
  a_write_shape: assert property (p_write_shape) else $error("write pins wrong");
  property p_idle; o_request_ready |-> !sel && ln_n == 2'h3; endproperty
  a_idle: assert property (p_idle) else $error("idle not standby");
  // data stays one cycle past the strobe rise as hold, never longer
  property p_no_fight; (|o_ram_data_oe) |-> oe_n && (!we_n || $past(!we_n)); endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives while outputs on");
  property p_release; $rose(oe_n) |-> (o_ram_data_oe == '0) [*2]; endproperty
  a_release: assert property (p_release) else $error("bus driven too soon");
  property p_answer; take && !i_request.write |=> !oe_n ##4 o_answer_valid; endproperty
  a_answer: assert property (p_answer) else $error("read answer late");
  property p_lanes; take |=> ln_n == ~$past(i_request.lanes); endproperty
  a_lanes: assert property (p_lanes) else $error("lane map wrong");
  // one low cycle gives 50 ns, above every least figure of the write
  property p_write_end;
    $rose(we_n) |-> $stable(o_pins.address) && $past(sel) && $past(|o_ram_data_oe) &&
      $stable(o_ram_data) ##1 $stable(o_pins.address);
  endproperty
  a_write_end: assert property (p_write_end) else $error("write end timing");
endmodule : asrc_host_monitor
`default_nettype wire

// ---- sim/asrc_sram_model.sv ----
// asrc_sram_model: behavioural async sram die
// assumes the bench resolves host and model onto one data bus
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model
  import asrc_pkg::*;
#(
  parameter int unsigned ACCESS_NS = 20
) (
  // sram pins
  input  wire asrc_pkg::asrc_pins_type i_pins,
  input  wire logic [DATA_WIDTH-1:0]   i_data,
  output logic      [DATA_WIDTH-1:0]   o_data
);
  logic [15:0] mem [int];
  logic [15:0] word;
  wire logic [15:0] mask = {{8{!i_pins.upper_byte_lane_n}}, {8{!i_pins.lower_byte_lane_n}}};
  wire logic sel = !i_pins.ram_select_active_low && i_pins.ram_select_active_high;
  wire logic wr = sel && !i_pins.ram_write_strobe_n && mask != 0;
  wire logic rd = sel && i_pins.ram_write_strobe_n && !i_pins.ram_output_strobe_n && mask != 0;
  always @(i_pins or i_data or wr) begin
    word = mem.exists(i_pins.address) ? mem[i_pins.address] : 16'h0000;
    if (wr) begin
      word = (word & ~mask) | (i_data & mask);
      mem[i_pins.address] = word;
    end
  end
  // released or unselected lanes show the inverse, never a stale match
  assign #(ACCESS_NS) o_data = rd ? ((word & mask) | (~word & ~mask)) : ~word;
endmodule : asrc_sram_model
`default_nettype wire

// ---- sim/async_sram_access_timing_tb_top.sv ----
// async_sram_access_timing_tb_top: bench for asrc_host with the sram model
// assumes package, design, model and monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module async_sram_access_timing_tb_top;
  import asrc_pkg::*;
  typedef struct packed {
    asrc_request_type req;
    logic [15:0]      exp;
  } asrc_row_type;
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic             valid = 1'b0;
  asrc_request_type req = '0;
  int               fails = 0;
  int               check_count = 0;
  logic             ready;
  logic             ans_valid;
  logic [15:0]      ans_data, host_data, host_oe, model_data, bus;
  asrc_pins_type    pins;
  asrc_row_type rows [8] = '{
    '{'{1'b1, 18'h00001, 16'h1234, 2'h3}, 16'h0000}, '{'{1'b0, 18'h00001, 16'h0000, 2'h3}, 16'h1234},
    '{'{1'b1, 18'h3FFFF, 16'hABCD, 2'h1}, 16'h0000}, '{'{1'b0, 18'h3FFFF, 16'h0000, 2'h3}, 16'h00CD},
    '{'{1'b1, 18'h3FFFF, 16'h5500, 2'h2}, 16'h0000}, '{'{1'b0, 18'h3FFFF, 16'h0000, 2'h2}, 16'h5500},
    '{'{1'b0, 18'h3FFFF, 16'h0000, 2'h1}, 16'h00CD}, '{'{1'b0, 18'h00001, 16'h0000, 2'h3}, 16'h1234}};
  always #25 clock = ~clock;
  assign bus = (host_data & host_oe) | (model_data & ~host_oe);
  asrc_host i_dut (.i_clock(clock), .i_reset_n(reset_n), .i_request_valid(valid), .o_request_ready(ready),
    .i_request(req), .o_answer_valid(ans_valid), .o_answer_data(ans_data), .o_pins(pins),
    .i_ram_data(bus), .o_ram_data(host_data), .o_ram_data_oe(host_oe));
  asrc_sram_model i_ram (.i_pins(pins), .i_data(bus), .o_data(model_data));
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic step();
    @(posedge clock);
    #5;
  endtask : step
  task automatic run(input asrc_row_type r);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    valid = 1'b1;
    req = r.req;
    step();
    valid = 1'b0;
    if (!r.req.write) begin
      n = 0;
      while (ans_valid !== 1'b1 && n < 20) begin
        step();
        n++;
      end
      check("latency", 16'(n), 16'(READ_CYCLES + 2));
      check("answer", ans_data, r.exp);
    end
  endtask : run
  task automatic close_out();
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge clock);
    #5;
    reset_n = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // no lanes chosen: nothing may start
    req = '{1'b1, 18'h00002, 16'hFFFF, 2'h0};
    valid = 1'b1;
    repeat (3) step();
    valid = 1'b0;
    check("standby", {13'h0000, ready, pins.upper_byte_lane_n, pins.lower_byte_lane_n}, 16'h0007);
    // reset in mid read, stored words must survive
    req = rows[1].req;
    valid = 1'b1;
    step();
    valid = 1'b0;
    check("strobe", {15'h0000, pins.ram_output_strobe_n}, 16'h0000);
    reset_n = 1'b0;
    step();
    check("reset pins", {host_oe[13:0], pins.ram_select_active_low, pins.ram_select_active_high}, 16'h0002);
    reset_n = 1'b1;
    run(rows[7]);
    close_out();
  end
  initial begin
    #200000;
    fails++;
    close_out();
  end
endmodule : async_sram_access_timing_tb_top
bind asrc_host asrc_host_monitor i_mon (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_request_valid(i_request_valid), .o_request_ready(o_request_ready), .i_request(i_request),
  .o_answer_valid(o_answer_valid), .o_pins(o_pins), .o_ram_data(o_ram_data), .o_ram_data_oe(o_ram_data_oe));
`default_nettype wire
